/* irq_routing_ext_edge.sv */
/*
 Interrupt source aggregation: external edge lines with pin multiplexer,
 clock-failure flag, system clock source select, fast oscillator trim and
 routing of peripheral requests onto 32 core interrupt numbers.
 Assumes peripherals give flag-and-enable as one pending bit per source,
 and the core vector controller handles priority and core enables.
*/
`timescale 1ns/1ps
module irq_routing_ext_edge
    import irq_routing_pkg::*;
(
    // Clock and reset
    input  wire logic                              i_clk,
    input  wire logic                              i_arst_n,
    // GPIO pins and multiplexer
    input  wire logic [`GPIO_COUNT-1:0]            i_gpio_level,
    input  wire logic [`GPIO_COUNT-1:0]            i_gpio_is_output,
    input  wire logic [`EXT_LINES*`PIN_SEL_W-1:0]  i_line_pin_sel,
    // External line control
    input  wire logic [`EXT_LINES-1:0]             i_rise_edge_enable,
    input  wire logic [`EXT_LINES-1:0]             i_fall_edge_enable,
    input  wire logic [`EXT_LINES-1:0]             i_rise_flag_set,
    input  wire logic [`EXT_LINES-1:0]             i_fall_flag_set,
    input  wire logic [`EXT_LINES-1:0]             i_rise_flag_clr,
    input  wire logic [`EXT_LINES-1:0]             i_fall_flag_clr,
    // Clock source and monitor
    input  wire logic                              i_clk_switch_req,
    input  wire logic [1:0]                        i_clk_switch_sel,
    input  wire logic                              i_clk_monitor_fault,
    input  wire logic                              i_clock_fail_irq_enable,
    input  wire logic                              i_clock_fail_flag_clr,
    // Oscillator trim
    input  wire logic                              i_trim_enable,
    input  wire logic                              i_slow_xtal_tick,
    // Peripheral requests
    input  wire logic [`PERIPH_SRCS-1:0]           i_periph_pending,
    input  wire logic [`PERIPH_SRCS-1:0]           i_module_irq_mask,
    // Vector query
    input  wire logic [`IRQ_NUM_W-1:0]             i_vec_num,
    // Flags and status
    output logic      [`EXT_LINES-1:0]             o_rise_edge_flag,
    output logic      [`EXT_LINES-1:0]             o_fall_edge_flag,
    output logic                                   o_clock_fail_flag,
    output logic      [3:0]                        o_sysclk_src,
    output logic      [`TRIM_W-1:0]                o_fast_osc_trim,
    // Toward the core vector controller
    output logic      [`IRQ_COUNT-1:0]             o_irq,
    output logic                                   o_stop_wake,
    output logic      [31:0]                       o_vec_addr
);
    localparam logic [`PERIPH_SRCS*`IRQ_NUM_W-1:0] SRC_MAP = `SRC_IRQ_MAP;
    localparam logic [`PERIPH_SRCS-1:0]            WAKE_MASK = `SRC_WAKE_MASK;
    localparam logic [2*`EXT_LINES-1:0]            GRP_MAP = `EXT_GRP_MAP;
    localparam logic [`TRIM_CNT_W-1:0]             TRIM_TGT =
        `TRIM_CNT_W'(`TRIM_TARGET_CYC);

    route_state_t                s_q;
    route_state_t                s_d;
    logic [`EXT_LINES-1:0]       line_level;
    logic [`EXT_LINES-1:0]       line_is_out;
    logic [`EXT_LINES-1:0]       rise_pulse;
    logic [`EXT_LINES-1:0]       fall_pulse;
    logic [`EXT_LINES-1:0]       rise_hit;
    logic [`EXT_LINES-1:0]       fall_hit;
    logic [`EXT_LINES-1:0]       line_req;
    logic [`PERIPH_SRCS-1:0]     src_req;
    logic [`PIN_SEL_W-1:0]       sel;
    logic [1:0]                  grp;
    logic [`IRQ_NUM_W-1:0]       num;
    clk_src_t                    tgt;
    logic                        xtal_src;

    // Pin multiplexer; an out-of-range pick acts as an output pin
    always_comb begin
        sel         = '0;
        line_level  = '1;
        line_is_out = '1;
        for (int i = 0; i < `EXT_LINES; i++) begin
            sel = i_line_pin_sel[i*`PIN_SEL_W +: `PIN_SEL_W];
            if (sel < `PIN_SEL_W'(`GPIO_COUNT)) begin
                line_level[i]  = i_gpio_level[sel];
                line_is_out[i] = i_gpio_is_output[sel];
            end
        end
    end

    irq_edge_sync u_edge (
        .i_clk        (i_clk),
        .i_arst_n     (i_arst_n),
        .i_level      (line_level),
        .o_rise_pulse (rise_pulse),
        .o_fall_pulse (fall_pulse)
    );

    // Output pins are blind to edges
    assign rise_hit = rise_pulse & i_rise_edge_enable & ~line_is_out;
    assign fall_hit = fall_pulse & i_fall_edge_enable & ~line_is_out;
    assign line_req = (s_q.rise_flag & i_rise_edge_enable)
                    | (s_q.fall_flag & i_fall_edge_enable);
    assign src_req  = i_periph_pending & i_module_irq_mask;
    assign xtal_src = (s_q.src == SRC_FAST_XTAL) || (s_q.src == SRC_SLOW_XTAL);

    always_comb begin
        case (i_clk_switch_sel)
            2'h0:    tgt = SRC_FAST_DIV2;
            2'h1:    tgt = SRC_SLOW_INT;
            2'h2:    tgt = SRC_FAST_XTAL;
            2'h3:    tgt = SRC_SLOW_XTAL;
            default: tgt = SRC_FAST_DIV2;
        endcase
    end

    always_comb begin
        s_d = s_q;
        grp = '0;
        num = '0;
        // Set beats a clear in the same cycle
        s_d.rise_flag = (s_q.rise_flag & ~i_rise_flag_clr)
                      | rise_hit | i_rise_flag_set;
        s_d.fall_flag = (s_q.fall_flag & ~i_fall_flag_clr)
                      | fall_hit | i_fall_flag_set;
        s_d.clk_fail = (s_q.clk_fail & ~i_clock_fail_flag_clr)
                     | (xtal_src & i_clk_monitor_fault);

        // Every switch passes through the fast internal source
        if (i_clk_switch_req) begin
            case (s_q.src)
                SRC_FAST_DIV2: s_d.src = tgt;
                SRC_SLOW_INT,
                SRC_FAST_XTAL,
                SRC_SLOW_XTAL: begin
                    if (tgt == SRC_FAST_DIV2) begin
                        s_d.src = tgt;
                    end
                end
                default: s_d.src = SRC_FAST_DIV2;
            endcase
        end

        // Trim: count system cycles per slow crystal period
        if (i_trim_enable && s_q.src == SRC_FAST_DIV2) begin
            if (i_slow_xtal_tick) begin
                s_d.trim_cnt = '0;
                if (s_q.trim_cnt > TRIM_TGT && s_q.trim != '0) begin
                    s_d.trim = s_q.trim - `TRIM_W'(1);
                end else if (s_q.trim_cnt < TRIM_TGT && s_q.trim != '1) begin
                    s_d.trim = s_q.trim + `TRIM_W'(1);
                end
            end else if (s_q.trim_cnt != '1) begin
                s_d.trim_cnt = s_q.trim_cnt + `TRIM_CNT_W'(1);
            end
        end else begin
            s_d.trim_cnt = '0;
        end

        // Routing; priority stays with the core
        s_d.irq = '0;
        for (int i = 0; i < `EXT_LINES; i++) begin
            grp = GRP_MAP[2*i +: 2];
            if (line_req[i]) begin
                s_d.irq[grp] = 1'b1;
            end
        end
        if (s_q.clk_fail && i_clock_fail_irq_enable) begin
            s_d.irq[`IRQ_CLK_FAIL] = 1'b1;
        end
        for (int j = 0; j < `PERIPH_SRCS; j++) begin
            num = SRC_MAP[j*`IRQ_NUM_W +: `IRQ_NUM_W];
            if (src_req[j]) begin
                s_d.irq[num] = 1'b1;
            end
        end
        s_d.irq = s_d.irq & ~`IRQ_RESERVED_MASK;

        // Only wake-capable sources may leave STOP
        s_d.wake = (|line_req)
                 | (s_q.clk_fail & i_clock_fail_irq_enable)
                 | (|(src_req & WAKE_MASK));

        s_d.vec = `VEC_BASE + {25'h0, i_vec_num, 2'h0};
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_q <= '{
                rise_flag: '0,
                fall_flag: '0,
                src:       SRC_FAST_DIV2,
                clk_fail:  1'b0,
                trim:      `TRIM_RST,
                trim_cnt:  '0,
                irq:       '0,
                wake:      1'b0,
                vec:       `VEC_BASE
            };
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rise_edge_flag  = s_q.rise_flag;
    assign o_fall_edge_flag  = s_q.fall_flag;
    assign o_clock_fail_flag = s_q.clk_fail;
    assign o_sysclk_src      = s_q.src;
    assign o_fast_osc_trim   = s_q.trim;
    assign o_irq             = s_q.irq;
    assign o_stop_wake       = s_q.wake;
    assign o_vec_addr        = s_q.vec;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);

    property p_clk_fail_set;
        xtal_src && i_clk_monitor_fault |=> o_clock_fail_flag;
    endproperty
    a_clk_fail_set: assert property (p_clk_fail_set)
        else $error("clock failure on crystal not flagged");

    property p_clk_fail_quiet;
        !xtal_src && !o_clock_fail_flag |=> !o_clock_fail_flag;
    endproperty
    a_clk_fail_quiet: assert property (p_clk_fail_quiet)
        else $error("clock fail flag set on internal source");

    property p_clk_fail_irq;
        o_clock_fail_flag && i_clock_fail_irq_enable
            |=> o_irq[4] ##0 o_stop_wake;
    endproperty
    a_clk_fail_irq: assert property (p_clk_fail_irq)
        else $error("clock fail request missing on number four");

    property p_clk_fail_gate;
        !o_clock_fail_flag |=> !o_irq[4];
    endproperty
    a_clk_fail_gate: assert property (p_clk_fail_gate)
        else $error("clock fail request without flag");

    property p_switch_via_fast;
        o_sysclk_src != SRC_FAST_DIV2 && i_clk_switch_sel != 2'h0
            |=> $stable(o_sysclk_src);
    endproperty
    a_switch_via_fast: assert property (p_switch_via_fast)
        else $error("source changed without passing fast internal");

    property p_reserved;
        (o_irq & `IRQ_RESERVED_MASK) == 32'h0000_0000;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("request on reserved number");

    property p_line_route;
        o_fall_edge_flag[9] && i_fall_edge_enable[9] |=> o_irq[2];
    endproperty
    a_line_route: assert property (p_line_route)
        else $error("external line routed to wrong number");

    property p_sw_set;
        |i_rise_flag_set
            |=> (o_rise_edge_flag & $past(i_rise_flag_set))
                == $past(i_rise_flag_set);
    endproperty
    a_sw_set: assert property (p_sw_set)
        else $error("software set of edge flag lost");

    property p_mask_gate;
        !i_module_irq_mask[25] |=> !o_irq[30];
    endproperty
    a_mask_gate: assert property (p_mask_gate)
        else $error("comparator request passed a clear mask");

    property p_uart_share;
        i_periph_pending[3] && i_module_irq_mask[3]
            |=> o_irq[7];
    endproperty
    a_uart_share: assert property (p_uart_share)
        else $error("shared uart request not on number seven");

    property p_wake_tk;
        i_periph_pending[26] && i_module_irq_mask[26] |=> o_stop_wake && o_irq[31];
    endproperty
    a_wake_tk: assert property (p_wake_tk)
        else $error("touch key did not request wake");

    property p_vec;
        1'b1 |=> o_vec_addr == 32'h0000_0040 + {25'h0, $past(i_vec_num), 2'h0};
    endproperty
    a_vec: assert property (p_vec)
        else $error("vector address wrong");

    property p_trim_idle;
        !i_trim_enable |=> $stable(o_fast_osc_trim);
    endproperty
    a_trim_idle: assert property (p_trim_idle)
        else $error("trim moved while disabled");

    property p_line0_route;
        o_rise_edge_flag[0] && i_rise_edge_enable[0]
            |=> o_irq[0];
    endproperty
    a_line0_route: assert property (p_line0_route)
        else $error("line 0 misrouted");

    property p_spi_share;
        i_periph_pending[9] && i_module_irq_mask[9]
            |=> o_irq[10];
    endproperty
    a_spi_share: assert property (p_spi_share)
        else $error("spi 2 misrouted");

    property p_tim_share;
        i_periph_pending[19] && i_module_irq_mask[19]
            |=> o_irq[20];
    endproperty
    a_tim_share: assert property (p_tim_share)
        else $error("timer 7 misrouted");

    property p_no_wake;
        src_req == 27'h000_0008 && line_req == '0 && !o_clock_fail_flag |=> !o_stop_wake;
    endproperty
    a_no_wake: assert property (p_no_wake)
        else $error("uart 2 woke chip");

    property p_flag_hold;
        o_fall_edge_flag[3] && !i_fall_flag_clr[3]
            |=> o_fall_edge_flag[3];
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("flag lost");

    property p_edge_flag;
        fall_pulse[3] && i_fall_edge_enable[3] && !line_is_out[3]
            |=> o_fall_edge_flag[3];
    endproperty
    a_edge_flag: assert property (p_edge_flag)
        else $error("edge not flagged");

    property p_switch_xtal;
        o_sysclk_src == SRC_FAST_DIV2 && i_clk_switch_req && i_clk_switch_sel == 2'h2
            |=> o_sysclk_src == SRC_FAST_XTAL;
    endproperty
    a_switch_xtal: assert property (p_switch_xtal)
        else $error("switch refused");
endmodule

/* irq_routing_map.svh */
/*
 Constants for the interrupt routing and external edge block: widths,
 routing tables, vector layout, reset values and timing counts.
 Assumes inclusion by bare name from the package; the design files get its constants through the package.
*/
`ifndef IRQ_ROUTING_MAP_SVH
`define IRQ_ROUTING_MAP_SVH
`define EXT_LINES         16
`define GPIO_COUNT        46
`define PIN_SEL_W         6
`define PERIPH_SRCS       27
`define IRQ_COUNT         32
`define IRQ_NUM_W         5
`define VEC_BASE          32'h0000_0040
`define IRQ_CLK_FAIL      5'h04
`define IRQ_RESERVED_MASK 32'h1e00_6020
`define EXT_GRP_MAP       32'hffaa_5554
`define SRC_IRQ_MAP {5'h1f, 5'h1e, 5'h1d, 5'h18, 5'h17, 5'h16, 5'h15, \
    5'h14, 5'h14, 5'h14, 5'h13, 5'h12, 5'h11, 5'h10, 5'h0f, 5'h0c, \
    5'h0b, 5'h0a, 5'h0a, 5'h09, 5'h08, 5'h07, 5'h08, 5'h07, 5'h08, \
    5'h07, 5'h06}
`define SRC_WAKE_MASK     27'h600_0077
`define SYS_CLK_HZ        10_000_000
`define SLOW_XTAL_HZ      32768
`define TRIM_TARGET_CYC   (`SYS_CLK_HZ / `SLOW_XTAL_HZ)
`define TRIM_W            8
`define TRIM_RST          8'h80
`define TRIM_CNT_W        10
`endif

/* irq_routing_pkg.sv */
/*
 Types shared by the interrupt routing block and its edge synchroniser.
 Assumes the constants header sits beside it.
*/
package irq_routing_pkg;
`include "irq_routing_map.svh"

    typedef enum logic [3:0] {
        SRC_FAST_DIV2 = 4'h1,
        SRC_SLOW_INT  = 4'h2,
        SRC_FAST_XTAL = 4'h4,
        SRC_SLOW_XTAL = 4'h8
    } clk_src_t;

    typedef struct packed {
        logic [`EXT_LINES-1:0] meta;
        logic [`EXT_LINES-1:0] sync;
        logic [`EXT_LINES-1:0] prev;
        logic [`EXT_LINES-1:0] rise;
        logic [`EXT_LINES-1:0] fall;
    } edge_state_t;

    typedef struct packed {
        logic [`EXT_LINES-1:0]  rise_flag;
        logic [`EXT_LINES-1:0]  fall_flag;
        clk_src_t               src;
        logic                   clk_fail;
        logic [`TRIM_W-1:0]     trim;
        logic [`TRIM_CNT_W-1:0] trim_cnt;
        logic [`IRQ_COUNT-1:0]  irq;
        logic                   wake;
        logic [31:0]            vec;
    } route_state_t;
endpackage

/* irq_edge_sync.sv */
/*
 Synchroniser and edge detector for the sixteen external lines.
 Assumes levels already picked by the pin multiplexer; one clock.
*/
`timescale 1ns/1ps
module irq_edge_sync
    import irq_routing_pkg::*;
(
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_arst_n,
    // Line levels
    input  wire logic [`EXT_LINES-1:0] i_level,
    // Edge pulses
    output logic      [`EXT_LINES-1:0] o_rise_pulse,
    output logic      [`EXT_LINES-1:0] o_fall_pulse
);
    edge_state_t s_q;
    edge_state_t s_d;

    // Idle high as pins sit pulled up
    always_comb begin
        s_d      = s_q;
        s_d.meta = i_level;
        s_d.sync = s_q.meta;
        s_d.prev = s_q.sync;
        s_d.rise = s_q.sync & ~s_q.prev;
        s_d.fall = ~s_q.sync & s_q.prev;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_q <= '{meta: '1, sync: '1, prev: '1, rise: '0, fall: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rise_pulse = s_q.rise;
    assign o_fall_pulse = s_q.fall;
endmodule

/* core_vec_model.sv */
/*
 Behavioural model of the core vector controller fed by the routing block.
 Assumes registered request levels from the block and a single clock.
*/
`timescale 1ns/1ps
module core_vec_model
    import irq_routing_pkg::*;
#(
    parameter logic [63:0] PRIO = 64'h0
)
(
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_arst_n,
    // Requests from the block
    input  wire logic [`IRQ_COUNT-1:0] i_irq,
    // Taken request
    output logic                       o_take,
    output logic      [`IRQ_NUM_W-1:0] o_take_num,
    output logic      [31:0]           o_take_vec
);
    logic [`IRQ_COUNT-1:0] prev_q;
    logic [`IRQ_COUNT-1:0] rise;
    logic [`IRQ_NUM_W-1:0] best;
    logic                  found;

    assign rise = i_irq & ~prev_q;

    // Four levels live here, two bits per number; ties go to lowest number
    always_comb begin
        best = '0;
        found = 1'b0;
        for (int n = 0; n < `IRQ_COUNT; n++) begin
            if (rise[n] && (!found || PRIO[2*n +: 2] < PRIO[2*best +: 2])) begin
                best = n[4:0];
                found = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            prev_q     <= '0;
            o_take     <= 1'b0;
            o_take_num <= '0;
            o_take_vec <= '0;
        end else begin
            prev_q     <= i_irq;
            o_take     <= found;
            o_take_num <= best;
            o_take_vec <= 32'h40 + {25'h0, best, 2'b00};
        end
    end
endmodule

/* irq_routing_ext_edge_tb.sv */
/*
 Self-checking bench for the interrupt routing block and its core model.
 Assumes the package, header, design and core model are compiled first.
*/
`timescale 1ns/1ps
module irq_routing_ext_edge_tb
    import irq_routing_pkg::*;
;
    localparam logic [31:0] RSVD = (32'h1 << 5) | (32'h3 << 13) | (32'hf << 25);
    logic                             i_clk, i_arst_n;
    logic [`GPIO_COUNT-1:0]           i_gpio_level, i_gpio_is_output;
    logic [`EXT_LINES*`PIN_SEL_W-1:0] i_line_pin_sel;
    logic [`EXT_LINES-1:0]            i_rise_edge_enable, i_fall_edge_enable;
    logic [`EXT_LINES-1:0]            i_rise_flag_set, i_fall_flag_set;
    logic [`EXT_LINES-1:0]            i_rise_flag_clr, i_fall_flag_clr;
    logic                             i_clk_switch_req, i_clk_monitor_fault;
    logic                             i_clock_fail_irq_enable, i_clock_fail_flag_clr;
    logic [1:0]                       i_clk_switch_sel;
    logic                             i_trim_enable, i_slow_xtal_tick;
    logic [`PERIPH_SRCS-1:0]          i_periph_pending, i_module_irq_mask;
    logic [`IRQ_NUM_W-1:0]            i_vec_num, take_num;
    logic [`EXT_LINES-1:0]            o_rise_edge_flag, o_fall_edge_flag;
    logic                             o_clock_fail_flag, o_stop_wake, take;
    logic [3:0]                       o_sysclk_src;
    logic [`TRIM_W-1:0]               o_fast_osc_trim;
    logic [`IRQ_COUNT-1:0]            o_irq;
    logic [31:0]                      o_vec_addr, take_vec;
    int                               miscompares = 0;
    int                               tests_run = 0;
    int                               exp_q[$];

    irq_routing_ext_edge DUT (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_gpio_level(i_gpio_level),
        .i_gpio_is_output(i_gpio_is_output), .i_line_pin_sel(i_line_pin_sel),
        .i_rise_edge_enable(i_rise_edge_enable), .i_fall_edge_enable(i_fall_edge_enable),
        .i_rise_flag_set(i_rise_flag_set), .i_fall_flag_set(i_fall_flag_set),
        .i_rise_flag_clr(i_rise_flag_clr), .i_fall_flag_clr(i_fall_flag_clr),
        .i_clk_switch_req(i_clk_switch_req), .i_clk_switch_sel(i_clk_switch_sel),
        .i_clk_monitor_fault(i_clk_monitor_fault),
        .i_clock_fail_irq_enable(i_clock_fail_irq_enable),
        .i_clock_fail_flag_clr(i_clock_fail_flag_clr), .i_trim_enable(i_trim_enable),
        .i_slow_xtal_tick(i_slow_xtal_tick), .i_periph_pending(i_periph_pending),
        .i_module_irq_mask(i_module_irq_mask), .i_vec_num(i_vec_num),
        .o_rise_edge_flag(o_rise_edge_flag), .o_fall_edge_flag(o_fall_edge_flag),
        .o_clock_fail_flag(o_clock_fail_flag), .o_sysclk_src(o_sysclk_src),
        .o_fast_osc_trim(o_fast_osc_trim), .o_irq(o_irq), .o_stop_wake(o_stop_wake),
        .o_vec_addr(o_vec_addr)
    );

    core_vec_model core (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_irq(o_irq),
        .o_take(take), .o_take_num(take_num), .o_take_vec(take_vec)
    );

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic switch_src(input logic [1:0] s);
        i_clk_switch_sel = s;
        i_clk_switch_req = 1'b1;
        cyc(1);
        i_clk_switch_req = 1'b0;
        cyc(2);
    endtask

    task automatic tick();
        i_slow_xtal_tick = 1'b1;
        cyc(1);
        i_slow_xtal_tick = 1'b0;
    endtask

    function automatic int grp(input int i);
        return (i == 0) ? 0 : (i < 8) ? 1 : (i < 12) ? 2 : 3;
    endfunction

    function automatic int src_num(input int k);
        case (k)
            0: return 6;
            1, 3, 5: return 7;
            2, 4, 6: return 8;
            7: return 9;
            8, 9: return 10;
            10: return 11;
            11: return 12;
            17, 18, 19: return 20;
            20, 21, 22, 23: return k + 1;
            24: return 29;
            25, 26: return k + 5;
            default: return k + 3;
        endcase
    endfunction

    // Each rising request taken by the core must match the oldest note
    always @(negedge i_clk) begin
        if (take === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(32'(take_num), 32'hff, "request nobody expected");
            end else begin
                check(32'(take_num), exp_q[0], "request number");
                check(take_vec, 32'h40 + 4 * exp_q[0], "taken vector");
                void'(exp_q.pop_front());
            end
        end
    end

    initial begin
        #(100 * 20000);
        miscompares++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        int p;
        int t0;
        {i_arst_n, i_gpio_is_output, i_rise_edge_enable, i_fall_edge_enable} = '0;
        {i_rise_flag_set, i_fall_flag_set, i_rise_flag_clr, i_fall_flag_clr} = '0;
        {i_clk_switch_req, i_clk_switch_sel, i_clk_monitor_fault} = '0;
        {i_clock_fail_irq_enable, i_clock_fail_flag_clr, i_trim_enable} = '0;
        {i_slow_xtal_tick, i_periph_pending, i_module_irq_mask, i_vec_num} = '0;
        i_gpio_level = '1;
        i_line_pin_sel = '1;
        p = $urandom(32'h13b8);
        cyc(20);
        i_arst_n = 1'b1;
        cyc(1);
        check(o_irq, 0, "request after reset");
        check(32'(o_sysclk_src), 32'h1, "source after reset");
        check(32'(o_fast_osc_trim), 32'h80, "trim after reset");
        check(o_vec_addr, 32'h40, "vector after reset");
        // Every line, from a random pin, both edges
        for (int i = 0; i < 16; i++) begin
            p = $urandom % 46;
            i_line_pin_sel[i*6 +: 6] = 6'(p);
            i_rise_edge_enable[i] = 1'b1;
            i_fall_edge_enable[i] = 1'b1;
            cyc(3);
            i_gpio_level[p] = 1'b0;
            exp_q.push_back(grp(i));
            cyc(6);
            check(32'(o_fall_edge_flag), 32'h1 << i, "fall flag");
            check(32'(o_stop_wake), 1, "wake on line");
            i_fall_flag_clr[i] = 1'b1;
            cyc(1);
            i_fall_flag_clr[i] = 1'b0;
            cyc(2);
            i_gpio_level[p] = 1'b1;
            exp_q.push_back(grp(i));
            cyc(6);
            check(32'(o_rise_edge_flag), 32'h1 << i, "rise flag");
            i_rise_flag_clr[i] = 1'b1;
            cyc(1);
            {i_rise_flag_clr[i], i_rise_edge_enable[i], i_fall_edge_enable[i]} = '0;
            i_line_pin_sel[i*6 +: 6] = 6'h3f;
            cyc(3);
        end
        // Fall-only line ignores rises, and an output pin is not watched
        i_line_pin_sel[18 +: 6] = 6'd7;
        i_fall_edge_enable[3] = 1'b1;
        cyc(3);
        i_gpio_level[7] = 1'b0;
        exp_q.push_back(1);
        cyc(6);
        i_fall_flag_clr[3] = 1'b1;
        cyc(1);
        i_fall_flag_clr[3] = 1'b0;
        i_gpio_level[7] = 1'b1;
        cyc(6);
        check(32'(o_rise_edge_flag), 0, "rise while disabled");
        i_gpio_is_output[7] = 1'b1;
        i_gpio_level[7] = 1'b0;
        cyc(6);
        check(32'(o_fall_edge_flag), 0, "edge on output pin");
        i_gpio_level[7] = 1'b1;
        cyc(4);
        {i_gpio_is_output[7], i_fall_edge_enable[3]} = '0;
        // Software set acts as a real event
        i_rise_edge_enable[9] = 1'b1;
        i_rise_flag_set[9] = 1'b1;
        exp_q.push_back(2);
        cyc(1);
        i_rise_flag_set[9] = 1'b0;
        cyc(1);
        check(32'(o_rise_edge_flag), 32'h200, "software set");
        cyc(3);
        i_rise_flag_clr[9] = 1'b1;
        cyc(1);
        {i_rise_flag_clr[9], i_rise_edge_enable[9]} = '0;
        // Clock failure only while a crystal drives the clock
        i_clk_monitor_fault = 1'b1;
        cyc(3);
        check(32'(o_clock_fail_flag), 0, "fault on internal source");
        i_clk_monitor_fault = 1'b0;
        switch_src(2'd2);
        check(32'(o_sysclk_src), 32'h4, "switch to crystal");
        switch_src(2'd3);
        check(32'(o_sysclk_src), 32'h4, "direct switch refused");
        i_clk_monitor_fault = 1'b1;
        cyc(1);
        i_clk_monitor_fault = 1'b0;
        cyc(3);
        check(32'(o_clock_fail_flag), 1, "fault on crystal");
        check(32'(o_irq[4]), 0, "fault request without enable");
        i_clock_fail_irq_enable = 1'b1;
        exp_q.push_back(4);
        cyc(4);
        i_clock_fail_flag_clr = 1'b1;
        cyc(1);
        i_clock_fail_flag_clr = 1'b0;
        cyc(2);
        check(32'(o_irq[4]), 0, "fault request after clear");
        i_clock_fail_irq_enable = 1'b0;
        switch_src(2'd0);
        check(32'(o_sysclk_src), 32'h1, "back to internal");
        // Each peripheral source, masked then unmasked
        for (int k = 0; k < 27; k++) begin
            i_module_irq_mask = 27'($urandom) & ~(27'h1 << k);
            i_periph_pending[k] = 1'b1;
            cyc(3);
            check(o_irq, 0, "masked source");
            i_module_irq_mask[k] = 1'b1;
            exp_q.push_back(src_num(k));
            cyc(3);
            check(32'(o_stop_wake), 32'(k inside {0, 1, 2, 4, 5, 6, 25, 26}), "wake");
            check(o_irq & RSVD, 0, "reserved number");
            i_periph_pending[k] = 1'b0;
            cyc(3);
        end
        for (int n = 0; n < 32; n++) begin
            i_vec_num = 5'(n);
            cyc(2);
            check(o_vec_addr, 32'h40 + 4 * n, "vector address");
        end
        // Short tick spacing means a slow oscillator, long spacing a fast one
        i_trim_enable = 1'b1;
        tick();
        cyc(2);
        t0 = int'(o_fast_osc_trim);
        repeat (3) begin
            cyc(200);
            tick();
        end
        cyc(2);
        check(32'(o_fast_osc_trim), 32'(t0 + 3), "trim raised");
        repeat (3) begin
            cyc(400);
            tick();
        end
        cyc(2);
        check(32'(o_fast_osc_trim), 32'(t0), "trim lowered");
        cyc(5);
        check(32'(exp_q.size()), 0, "requests never seen");
        complete_run();
    end
endmodule
